// ===== dv/bpc_flash_model.sv
// Behavioural flash on the host's far side: logs each bus cycle and answers reads.
// Assumes address and data stay put while the chip is selected.
`timescale 1ns/1ps
module bpc_flash_model (
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [24:0] i_addr,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq
);
    logic [41:0] log[$];
    logic [15:0] held = 16'h0000;
    always @(posedge i_we_n) if (!i_ce_n) log.push_back({1'b0, i_addr, i_dq});
    always @(posedge i_oe_n) if (!i_ce_n) log.push_back({1'b1, i_addr, 16'h0000});
    // A released bus inverts at each select, enable or address change, so it shows the read value again once chip select rises.
    always @(i_ce_n, i_oe_n, i_addr) begin
        held = (!i_ce_n && !i_oe_n) ? 16'hA5C3 ^ {i_addr[7:0], i_addr[7:0]} : ~held;
    end
    assign o_dq = held;
endmodule

// ===== dv/bpc_host_bench.sv
// Bench for the protection host: register tasks issue commands, the model logs cycles.
// Assumes the flash model and the bound checker from the dv folder.
`timescale 1ns/1ps
module bpc_host_bench;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic [31:0] o_reg_rdata;
    logic [31:0] rv;
    logic o_flash_ce_n, o_flash_oe_n, o_flash_we_n, o_flash_byte_n, o_flash_dq_oe;
    logic [24:0] o_flash_addr;
    logic [15:0] o_flash_dq_out, i_flash_dq;
    logic [41:0] exp_q[$];
    logic [7:0] codes[6] = '{8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0, 8'h88};
    logic [63:0] pw = 64'h5566778811223344;
    localparam logic [24:0] ADR = 25'h0123456;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    initial forever #12.5 i_mclk = ~i_mclk;
    bpc_host DUT (.i_mclk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata, .o_flash_ce_n, .o_flash_oe_n, .o_flash_we_n, .o_flash_byte_n,
        .o_flash_addr, .o_flash_dq_out, .o_flash_dq_oe, .i_flash_dq);
    bpc_flash_model FM (.i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n), .i_we_n(o_flash_we_n),
        .i_addr(o_flash_addr), .i_dq(o_flash_dq_out), .o_dq(i_flash_dq));
    function automatic logic [15:0] f(input logic [24:0] a);
        f = 16'hA5C3 ^ {a[7:0], a[7:0]};
    endfunction
    task automatic print_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic cmp(input logic [41:0] got, input logic [41:0] want);
        checked++;
        if (got !== want) begin
            err_total++;
            $display("Error t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 rv = o_reg_rdata;
    endtask
    task automatic e(input logic [24:0] a, input logic [15:0] d);
        exp_q.push_back({1'b0, a, d});
    endtask
    // Issues a command, polls busy, then compares the logged cycles in order.
    task automatic run(input logic [3:0] c);
        wr(bpc_pkg::REG_CMD, {28'h0, c});
        rv = 32'h1;
        for (int i = 0; i < 2000 && rv[0] !== 1'b0; i++) rd(bpc_pkg::REG_STATUS);
        cmp(42'(rv[0]), 42'h0);
        cmp(42'(FM.log.size()), 42'(exp_q.size()));
        foreach (exp_q[i]) cmp(FM.log[i], exp_q[i]);
        FM.log.delete();
        exp_q.delete();
        $display("command %h finished", c);
    endtask
    task automatic seq2(input logic [15:0] d1, input logic [24:0] a2, input logic [15:0] d2,
                        input logic [3:0] c);
        e(25'h0, d1);
        e(a2, d2);
        run(c);
    endtask
    task automatic enter(input logic [7:0] code, input logic x8);
        wr(bpc_pkg::REG_WDATA, {24'h0, code});
        e(x8 ? 25'hAAA : 25'h555, 16'h00AA);
        e(x8 ? 25'h555 : 25'h2AA, 16'h0055);
        e(x8 ? 25'hAAA : 25'h555, {8'h00, code});
        run(bpc_pkg::CMD_ENTER);
    endtask
    task automatic unlock(input logic x8);
        e(25'h0, 16'h0025);
        e(25'h0, 16'h0003);
        for (int n = 0; n < (x8 ? 8 : 4); n++) e(25'(n), x8 ? 16'(pw[8*n +: 8]) : pw[16*n +: 16]);
        e(25'h0, 16'h0029);
        run(bpc_pkg::CMD_UNLOCK_PW);
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(bpc_pkg::REG_CONFIG);
        cmp(42'({rv, o_flash_byte_n}), 42'h1);
        foreach (codes[i]) enter(codes[i], 1'b0);
        seq2(16'h0090, 25'h0, 16'h0000, bpc_pkg::CMD_EXIT);
        wr(bpc_pkg::REG_ADDR, {7'h0, ADR});
        wr(bpc_pkg::REG_WDATA, 32'h0000BEEF);
        seq2(16'h00A0, ADR, 16'hBEEF, bpc_pkg::CMD_PROG_LOCK);
        seq2(16'h00A0, ADR, 16'hBEEF, bpc_pkg::CMD_PROG_PW);
        seq2(16'h00A0, ADR, 16'h0000, bpc_pkg::CMD_NV_PROG);
        seq2(16'h00A0, ADR, 16'h0000, bpc_pkg::CMD_VOL_SET);
        seq2(16'h00A0, ADR, 16'h0001, bpc_pkg::CMD_VOL_CLR);
        seq2(16'h0080, 25'h0, 16'h0030, bpc_pkg::CMD_NV_CLEAR);
        seq2(16'h00A0, 25'h0, 16'h0000, bpc_pkg::CMD_PROG_LOCKBIT);
        exp_q.push_back({1'b1, ADR, 16'h0});
        run(bpc_pkg::CMD_READ_ONE);
        cmp(42'(rv[31:16]), 42'(f(ADR)));
        for (int n = 0; n < 4; n++) exp_q.push_back({1'b1, 25'(n), 16'h0});
        run(bpc_pkg::CMD_READ_PW);
        rd(bpc_pkg::REG_PW_RD_LO);
        cmp(42'(rv), 42'({f(25'h1), f(25'h0)}));
        rd(bpc_pkg::REG_PW_RD_HI);
        cmp(42'(rv), 42'({f(25'h3), f(25'h2)}));
        wr(bpc_pkg::REG_PW_LO, pw[31:0]);
        wr(bpc_pkg::REG_PW_HI, pw[63:32]);
        unlock(1'b0);
        wr(bpc_pkg::REG_CONFIG, 32'h1);
        rd(bpc_pkg::REG_CONFIG);
        cmp(42'({rv, o_flash_byte_n}), 42'h2);
        enter(8'hC0, 1'b1);
        unlock(1'b1);
        wr(bpc_pkg::REG_CMD, 32'hC);
        rd(bpc_pkg::REG_STATUS);
        cmp(42'(rv[2:1]), 42'h3);
        rd(8'hFC);
        cmp(42'(rv), 42'h0);
        print_verdict();
    end
endmodule

// ===== dv/bpc_host_checker.sv
// Checker on the host's flash pins and register read port.
// Assumes the single system clock domain; bound to every host below.
`timescale 1ns/1ps
module bpc_host_checker (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic o_flash_ce_n,
    input wire logic o_flash_oe_n,
    input wire logic o_flash_we_n,
    input wire logic [24:0] o_flash_addr,
    input wire logic [15:0] o_flash_dq_out,
    input wire logic o_flash_dq_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    localparam int GAP_MIN = 239;
    logic [7:0] gap;
    logic [7:0] next_gap;
    // Counts from the confirm write of one unlock to the first write of the next.
    always_comb begin
        next_gap = (gap == 8'hFF) ? gap : gap + 8'h01;
        if (!o_flash_we_n && o_flash_dq_out == 16'h0029 && o_flash_addr == 25'h0) begin
            next_gap = 8'h00;
        end
    end
    always_ff @(posedge i_mclk) begin
        gap <= i_sys_rst ? 8'hFF : next_gap;
    end
    sequence we_pulse; !o_flash_we_n [*2] ##1 o_flash_we_n; endsequence
    sequence oe_pulse; !o_flash_oe_n [*6] ##1 o_flash_oe_n; endsequence
    we_len_a: assert property ($fell(o_flash_we_n) |-> we_pulse)
        else $error("write pulse length wrong");
    rd_len_a: assert property ($fell(o_flash_oe_n) |-> oe_pulse)
        else $error("read pulse length wrong");
    we_sel_a: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_dq_oe
        && o_flash_oe_n)
        else $error("write cycle pins wrong");
    rd_sel_a: assert property (!o_flash_oe_n |-> !o_flash_ce_n && !o_flash_dq_oe
        && o_flash_we_n)
        else $error("read cycle pins wrong");
    hold_a: assert property (!o_flash_ce_n && !$past(o_flash_ce_n) |-> $stable(o_flash_addr)
        && $stable(o_flash_dq_out))
        else $error("address or data moved in cycle");
    ce_gap_a: assert property ($rose(o_flash_ce_n) |=> o_flash_ce_n)
        else $error("chip select gap too short");
    rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    unlock_gap_a: assert property ($fell(o_flash_we_n) && o_flash_dq_out == 16'h0025
        && o_flash_addr == 25'h0 |-> gap >= GAP_MIN)
        else $error("unlock commands too close");
endmodule
bind bpc_host bpc_host_checker CHK (.i_mclk, .i_sys_rst, .i_reg_rd, .o_reg_rdata,
    .o_flash_ce_n, .o_flash_oe_n, .o_flash_we_n, .o_flash_addr, .o_flash_dq_out, .o_flash_dq_oe);

// ===== hw/bpc_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, timed from the system clock.
// Assumes the flash data pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module bpc_bus_cycle (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic i_rd,
    input wire logic [24:0] i_addr,
    input wire logic [15:0] i_data,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [24:0] o_addr,
    output logic [15:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [15:0] i_dq
);
    typedef enum logic [3:0] {
        CY_IDLE = 4'b0001,
        CY_SETUP = 4'b0010,
        CY_STROBE = 4'b0100,
        CY_HOLD = 4'b1000
    } bpc_cyc_t;

    bpc_cyc_t state, next_state;
    logic rd, next_rd;
    logic [3:0] cnt, next_cnt;
    logic ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n;
    logic [24:0] addr, next_addr;
    logic [15:0] dq_out, next_dq_out, rdata, next_rdata;
    logic dq_oe, next_dq_oe, done, next_done;
    logic [15:0] dq_meta, dq_sync;

    always_comb begin
        next_state = state;
        next_rd = rd;
        next_cnt = cnt;
        next_ce_n = ce_n;
        next_oe_n = oe_n;
        next_we_n = we_n;
        next_addr = addr;
        next_dq_out = dq_out;
        next_dq_oe = dq_oe;
        next_rdata = rdata;
        next_done = 1'b0;
        case (state)
            CY_IDLE: begin
                if (i_start) begin
                    next_rd = i_rd;
                    next_addr = i_addr;
                    next_dq_out = i_rd ? 16'h0000 : i_data;
                    next_dq_oe = ~i_rd;
                    next_ce_n = 1'b0;
                    next_state = CY_SETUP;
                end
            end
            CY_SETUP: begin
                // Reads never drive the data pins, so the host only asserts output enable.
                if (rd) begin
                    next_oe_n = 1'b0;
                    next_cnt = bpc_pkg::RD_WAIT_CYC;
                end else begin
                    next_we_n = 1'b0;
                    next_cnt = bpc_pkg::WP_CYC;
                end
                next_state = CY_STROBE;
            end
            CY_STROBE: begin
                if (cnt > 4'h1) begin
                    next_cnt = cnt - 4'h1;
                end else begin
                    if (rd) begin
                        next_rdata = dq_sync;
                    end
                    next_oe_n = 1'b1;
                    next_we_n = 1'b1;
                    next_state = CY_HOLD;
                end
            end
            CY_HOLD: begin
                next_ce_n = 1'b1;
                next_dq_oe = 1'b0;
                next_done = 1'b1;
                next_state = CY_IDLE;
            end
            default: begin
                next_state = CY_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        dq_meta <= i_dq;
        dq_sync <= dq_meta;
        if (i_sys_rst) begin
            state <= CY_IDLE;
            rd <= 1'b0;
            cnt <= 4'h0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            addr <= 25'h0000000;
            dq_out <= 16'h0000;
            dq_oe <= 1'b0;
            rdata <= 16'h0000;
            done <= 1'b0;
        end else begin
            state <= next_state;
            rd <= next_rd;
            cnt <= next_cnt;
            ce_n <= next_ce_n;
            oe_n <= next_oe_n;
            we_n <= next_we_n;
            addr <= next_addr;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
            rdata <= next_rdata;
            done <= next_done;
        end
    end

    assign o_done = done;
    assign o_rdata = rdata;
    assign o_ce_n = ce_n;
    assign o_oe_n = oe_n;
    assign o_we_n = we_n;
    assign o_addr = addr;
    assign o_dq_out = dq_out;
    assign o_dq_oe = dq_oe;

endmodule

// ===== hw/bpc_host.sv
// Host controller that runs block-protection command sequences on a parallel flash.
// Assumes software on a plain register port and an asynchronous flash on the pins.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module bpc_host (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_flash_ce_n,
    output logic o_flash_oe_n,
    output logic o_flash_we_n,
    output logic o_flash_byte_n,
    output logic [24:0] o_flash_addr,
    output logic [15:0] o_flash_dq_out,
    output logic o_flash_dq_oe,
    input wire logic [15:0] i_flash_dq
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_GAP = 4'b0010,
        ST_ISSUE = 4'b0100,
        ST_WAIT = 4'b1000
    } bpc_state_t;

    bpc_state_t state, next_state;
    logic [3:0] cmd, next_cmd, idx, next_idx;
    logic byte_mode, next_byte_mode, byte_n, next_byte_n;
    logic [24:0] addr_r, next_addr_r;
    logic [15:0] wdata_r, next_wdata_r, last_rd, next_last_rd;
    logic [63:0] pw_w, next_pw_w, pw_rd, next_pw_rd;
    logic [7:0] gap_cnt, next_gap_cnt;
    logic reject, next_reject;
    logic start, next_start;
    logic [31:0] rdata, next_rdata;
    bpc_pkg::bpc_step_t step, next_step, cur_step;
    logic eng_done;
    logic [15:0] eng_rdata;
    logic busy;
    logic [31:0] status_word;

    assign busy = (state != ST_IDLE);
    assign cur_step = bpc_pkg::bpc_step(cmd, idx, byte_mode, addr_r, wdata_r, pw_w);
    assign status_word = {last_rd, 13'h0000, reject, (gap_cnt != 8'h00), busy};

    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_idx = idx;
        next_byte_mode = byte_mode;
        next_addr_r = addr_r;
        next_wdata_r = wdata_r;
        next_pw_w = pw_w;
        next_pw_rd = pw_rd;
        next_last_rd = last_rd;
        next_reject = reject;
        next_step = step;
        next_start = 1'b0;
        // Spacing counter runs from the end of the last unlock confirm cycle.
        next_gap_cnt = (gap_cnt != 8'h00) ? gap_cnt - 8'h01 : 8'h00;

        // Software writes; settings are frozen while a sequence runs so that the
        // cycle table never changes under a command in flight.
        if (i_reg_wr && !busy) begin
            case (i_reg_addr)
                bpc_pkg::REG_CMD: begin
                    if (i_reg_wdata[3:0] <= bpc_pkg::CMD_LAST) begin
                        next_cmd = i_reg_wdata[3:0];
                        next_idx = 4'h0;
                        next_reject = 1'b0;
                        // Hold an early unlock back instead of letting the device drop it.
                        if (i_reg_wdata[3:0] == bpc_pkg::CMD_UNLOCK_PW && gap_cnt != 8'h00) begin
                            next_state = ST_GAP;
                        end else begin
                            next_state = ST_ISSUE;
                        end
                    end else begin
                        next_reject = 1'b1;
                    end
                end
                bpc_pkg::REG_CONFIG: begin
                    next_byte_mode = i_reg_wdata[bpc_pkg::CFG_BYTE_MODE_BIT];
                end
                bpc_pkg::REG_ADDR: begin
                    next_addr_r = i_reg_wdata[24:0];
                end
                bpc_pkg::REG_WDATA: begin
                    next_wdata_r = i_reg_wdata[15:0];
                end
                bpc_pkg::REG_PW_LO: begin
                    next_pw_w[31:0] = i_reg_wdata;
                end
                bpc_pkg::REG_PW_HI: begin
                    next_pw_w[63:32] = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end else if (i_reg_wr && i_reg_addr == bpc_pkg::REG_CMD) begin
            next_reject = 1'b1;
        end

        case (state)
            ST_IDLE: begin
            end
            ST_GAP: begin
                if (gap_cnt == 8'h00) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                // The step table fills in addresses and codes for every sequence.
                next_step = cur_step;
                next_start = 1'b1;
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (eng_done) begin
                    if (step.rd) begin
                        next_last_rd = eng_rdata;
                        if (cmd == bpc_pkg::CMD_READ_PW) begin
                            if (byte_mode) begin
                                next_pw_rd[{idx[2:0], 3'b000} +: 8] = eng_rdata[7:0];
                            end else begin
                                next_pw_rd[{idx[1:0], 4'b0000} +: 16] = eng_rdata;
                            end
                        end
                    end
                    if (step.last) begin
                        next_state = ST_IDLE;
                        if (cmd == bpc_pkg::CMD_UNLOCK_PW) begin
                            next_gap_cnt = bpc_pkg::GAP_CYC;
                        end
                    end else begin
                        next_idx = idx + 4'h1;
                        next_state = ST_ISSUE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        next_byte_n = ~next_byte_mode;
        next_rdata = 32'h00000000;
        if (i_reg_rd) begin
            case (i_reg_addr)
                bpc_pkg::REG_CMD: next_rdata = {28'h0000000, cmd};
                bpc_pkg::REG_CONFIG: next_rdata = {31'h00000000, byte_mode};
                bpc_pkg::REG_ADDR: next_rdata = {7'h00, addr_r};
                bpc_pkg::REG_WDATA: next_rdata = {16'h0000, wdata_r};
                bpc_pkg::REG_PW_LO: next_rdata = pw_w[31:0];
                bpc_pkg::REG_PW_HI: next_rdata = pw_w[63:32];
                bpc_pkg::REG_STATUS: next_rdata = status_word;
                bpc_pkg::REG_PW_RD_LO: next_rdata = pw_rd[31:0];
                bpc_pkg::REG_PW_RD_HI: next_rdata = pw_rd[63:32];
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            cmd <= bpc_pkg::CMD_ENTER;
            idx <= 4'h0;
            byte_mode <= bpc_pkg::CFG_BYTE_MODE_RESET;
            byte_n <= ~bpc_pkg::CFG_BYTE_MODE_RESET;
            addr_r <= 25'h0000000;
            wdata_r <= 16'h0000;
            pw_w <= bpc_pkg::PW_RESET;
            pw_rd <= 64'h0000000000000000;
            last_rd <= 16'h0000;
            gap_cnt <= 8'h00;
            reject <= 1'b0;
            step <= '0;
            start <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            idx <= next_idx;
            byte_mode <= next_byte_mode;
            byte_n <= next_byte_n;
            addr_r <= next_addr_r;
            wdata_r <= next_wdata_r;
            pw_w <= next_pw_w;
            pw_rd <= next_pw_rd;
            last_rd <= next_last_rd;
            gap_cnt <= next_gap_cnt;
            reject <= next_reject;
            step <= next_step;
            start <= next_start;
            rdata <= next_rdata;
        end
    end

    bpc_bus_cycle u_cycle (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_start(start),
        .i_rd(step.rd),
        .i_addr(step.addr),
        .i_data(step.data),
        .o_done(eng_done),
        .o_rdata(eng_rdata),
        .o_ce_n(o_flash_ce_n),
        .o_oe_n(o_flash_oe_n),
        .o_we_n(o_flash_we_n),
        .o_addr(o_flash_addr),
        .o_dq_out(o_flash_dq_out),
        .o_dq_oe(o_flash_dq_oe),
        .i_dq(i_flash_dq)
    );

    // The width pin follows the configuration register; low selects the 8-bit bus.
    assign o_flash_byte_n = byte_n;
    assign o_reg_rdata = rdata;

endmodule

// ===== hw/bpc_pkg.sv
// Constants, types and the cycle-step table for the block-protection command host.
// Assumes a 40 MHz system clock and an asynchronous parallel flash on the far side.
package bpc_pkg;

    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;

    // Timing in nanoseconds, and the clock counts derived from it.
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_WP_NS = 35;
    localparam int T_ACC_NS = 70;
    localparam int T_UNLOCK_GAP_NS = 6000;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RD_WAIT_CYC =
        4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1);
    localparam logic [7:0] GAP_CYC =
        8'((T_UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Flash bus addresses and codes.
    localparam logic [24:0] A_X8_FIRST = 25'h0000AAA;
    localparam logic [24:0] A_X8_SECOND = 25'h0000555;
    localparam logic [24:0] A_X16_FIRST = 25'h0000555;
    localparam logic [24:0] A_X16_SECOND = 25'h00002AA;
    localparam logic [24:0] A_ZERO = 25'h0000000;
    localparam logic [7:0] C_UNLOCK1 = 8'hAA;
    localparam logic [7:0] C_UNLOCK2 = 8'h55;
    localparam logic [7:0] C_EXIT1 = 8'h90;
    localparam logic [7:0] C_EXIT2 = 8'h00;
    localparam logic [7:0] C_PROG = 8'hA0;
    localparam logic [7:0] C_PW_UNLOCK1 = 8'h25;
    localparam logic [7:0] C_PW_UNLOCK2 = 8'h03;
    localparam logic [7:0] C_PW_CONFIRM = 8'h29;
    localparam logic [7:0] C_CLR_ALL1 = 8'h80;
    localparam logic [7:0] C_CLR_ALL2 = 8'h30;
    localparam logic [7:0] BIT_PROTECT = 8'h00;
    localparam logic [7:0] BIT_UNPROTECT = 8'h01;

    // Set-entry codes that software places in the data register for an entry command.
    localparam logic [7:0] SET_LOCK_REG = 8'h40;
    localparam logic [7:0] SET_PASSWORD = 8'h60;
    localparam logic [7:0] SET_NV_PROT = 8'hC0;
    localparam logic [7:0] SET_NV_LOCK = 8'h50;
    localparam logic [7:0] SET_VOL_PROT = 8'hE0;
    localparam logic [7:0] SET_EXT_MEM = 8'h88;

    // Host command codes.
    localparam logic [3:0] CMD_ENTER = 4'h0;
    localparam logic [3:0] CMD_EXIT = 4'h1;
    localparam logic [3:0] CMD_PROG_LOCK = 4'h2;
    localparam logic [3:0] CMD_READ_ONE = 4'h3;
    localparam logic [3:0] CMD_PROG_PW = 4'h4;
    localparam logic [3:0] CMD_READ_PW = 4'h5;
    localparam logic [3:0] CMD_UNLOCK_PW = 4'h6;
    localparam logic [3:0] CMD_NV_PROG = 4'h7;
    localparam logic [3:0] CMD_NV_CLEAR = 4'h8;
    localparam logic [3:0] CMD_VOL_SET = 4'h9;
    localparam logic [3:0] CMD_VOL_CLR = 4'hA;
    localparam logic [3:0] CMD_PROG_LOCKBIT = 4'hB;
    localparam logic [3:0] CMD_LAST = 4'hB;

    // Register offsets (byte addresses) and fields.
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_WDATA = 8'h0C;
    localparam logic [7:0] REG_PW_LO = 8'h10;
    localparam logic [7:0] REG_PW_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_PW_RD_LO = 8'h1C;
    localparam logic [7:0] REG_PW_RD_HI = 8'h20;
    localparam int CFG_BYTE_MODE_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_GAP_BIT = 1;
    localparam int ST_REJECT_BIT = 2;
    localparam int ST_RDATA_LSB = 16;
    localparam logic CFG_BYTE_MODE_RESET = 1'b0;
    localparam logic [63:0] PW_RESET = 64'hFFFFFFFFFFFFFFFF;

    typedef struct packed {
        logic last;
        logic rd;
        logic [24:0] addr;
        logic [15:0] data;
    } bpc_step_t;

    function automatic logic [15:0] bpc_portion(input logic [63:0] pw, input logic [2:0] n,
                                                input logic byte_mode);
        if (byte_mode) begin
            bpc_portion = {8'h00, pw[{n, 3'b000} +: 8]};
        end else begin
            bpc_portion = pw[{n[1:0], 4'b0000} +: 16];
        end
    endfunction

    function automatic bpc_step_t bpc_wr(input logic last, input logic [24:0] a,
                                         input logic [15:0] d);
        bpc_wr = '{last: last, rd: 1'b0, addr: a, data: d};
    endfunction

    // One bus cycle of a host command, selected by its position in the sequence.
    function automatic bpc_step_t bpc_step(input logic [3:0] cmd, input logic [3:0] idx,
                                           input logic byte_mode, input logic [24:0] addr,
                                           input logic [15:0] wdata, input logic [63:0] pw);
        logic [24:0] a1;
        logic [24:0] a2;
        logic [3:0] n_pw;
        a1 = byte_mode ? A_X8_FIRST : A_X16_FIRST;
        a2 = byte_mode ? A_X8_SECOND : A_X16_SECOND;
        n_pw = byte_mode ? 4'h8 : 4'h4;
        bpc_step = '{last: 1'b1, rd: 1'b1, addr: addr, data: 16'h0000};
        case (cmd)
            CMD_ENTER: begin
                if (idx == 4'h0) begin
                    bpc_step = bpc_wr(1'b0, a1, {8'h00, C_UNLOCK1});
                end else if (idx == 4'h1) begin
                    bpc_step = bpc_wr(1'b0, a2, {8'h00, C_UNLOCK2});
                end else begin
                    bpc_step = bpc_wr(1'b1, a1, {8'h00, wdata[7:0]});
                end
            end
            CMD_EXIT: begin
                bpc_step = bpc_wr(idx != 4'h0, A_ZERO,
                                  {8'h00, (idx == 4'h0) ? C_EXIT1 : C_EXIT2});
            end
            CMD_PROG_LOCK, CMD_PROG_PW: begin
                if (idx == 4'h0) begin
                    bpc_step = bpc_wr(1'b0, A_ZERO, {8'h00, C_PROG});
                end else begin
                    bpc_step = bpc_wr(1'b1, addr, wdata);
                end
            end
            CMD_READ_PW: begin
                bpc_step = '{last: idx == n_pw - 4'h1, rd: 1'b1, addr: 25'(idx),
                             data: 16'h0000};
            end
            CMD_UNLOCK_PW: begin
                if (idx == 4'h0) begin
                    bpc_step = bpc_wr(1'b0, A_ZERO, {8'h00, C_PW_UNLOCK1});
                end else if (idx == 4'h1) begin
                    bpc_step = bpc_wr(1'b0, A_ZERO, {8'h00, C_PW_UNLOCK2});
                end else if (idx < n_pw + 4'h2) begin
                    bpc_step = bpc_wr(1'b0, 25'(idx - 4'h2),
                                      bpc_portion(pw, 3'(idx - 4'h2), byte_mode));
                end else begin
                    bpc_step = bpc_wr(1'b1, A_ZERO, {8'h00, C_PW_CONFIRM});
                end
            end
            CMD_NV_PROG, CMD_VOL_SET, CMD_VOL_CLR, CMD_PROG_LOCKBIT: begin
                if (idx == 4'h0) begin
                    bpc_step = bpc_wr(1'b0, A_ZERO, {8'h00, C_PROG});
                end else begin
                    bpc_step = bpc_wr(1'b1, (cmd == CMD_PROG_LOCKBIT) ? A_ZERO : addr,
                                      {8'h00, (cmd == CMD_VOL_CLR) ? BIT_UNPROTECT
                                                                   : BIT_PROTECT});
                end
            end
            CMD_NV_CLEAR: begin
                bpc_step = bpc_wr(idx != 4'h0, A_ZERO,
                                  {8'h00, (idx == 4'h0) ? C_CLR_ALL1 : C_CLR_ALL2});
            end
            default: begin
                bpc_step = '{last: 1'b1, rd: 1'b1, addr: addr, data: 16'h0000};
            end
        endcase
    endfunction

endpackage
